// ### logic/ccm_edge_prescaler.sv
/*
 * Capture edge detector and prescaler. Emits one-cycle capture events.
 * Assumes pin_level is already synchronised to pclk.
 */
`timescale 1ns/1ns
module ccm_edge_prescaler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pin_level,
    input  wire logic [3:0] mode_code,
    output logic            capture_event
);
    logic       prev_ff;
    logic [3:0] count_ff;
    logic [3:0] nxt_count;
    logic       rise;
    logic       fall;
    logic       is_capture;

    assign rise       = pin_level & ~prev_ff;
    assign fall       = ~pin_level & prev_ff;
    assign is_capture = (mode_code[3:2] == 2'b01);

    // Edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= pin_level;
        end
    end

    // Event select; four-edge >= compare so a count left by a prior setting fires early
    always_comb begin
        nxt_count     = count_ff;
        capture_event = 1'b0;
        case (mode_code)
            ccm_pkg::MODE_CAP_FALL: begin
                capture_event = fall;
            end
            ccm_pkg::MODE_CAP_RISE: begin
                capture_event = rise;
            end
            ccm_pkg::MODE_CAP_RISE4: begin
                if (rise && count_ff >= ccm_pkg::PRESCALE_LAST4) begin
                    capture_event = 1'b1;
                    nxt_count     = 4'h0;
                end else if (rise) begin
                    nxt_count = count_ff + 4'h1;
                end
            end
            ccm_pkg::MODE_CAP_RISE16: begin
                if (rise && count_ff == ccm_pkg::PRESCALE_LAST16) begin
                    capture_event = 1'b1;
                    nxt_count     = 4'h0;
                end else if (rise) begin
                    nxt_count = count_ff + 4'h1;
                end
            end
            default: begin
                nxt_count = 4'h0;
            end
        endcase
        if (!is_capture) begin
            nxt_count = 4'h0;
        end
    end

    // Counter survives a switch between capture codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 4'h0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    property p_prescale_clear;
        @(posedge pclk) disable iff (!presetn)
        !is_capture |=> count_ff == 4'h0;
    endproperty
    a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared");

    property p_fourth_edge;
        @(posedge pclk) disable iff (!presetn)
        (mode_code == ccm_pkg::MODE_CAP_RISE4 && rise && count_ff == 4'h3) |-> capture_event ##1 count_ff == 4'h0;
    endproperty
    a_fourth_edge: assert property (p_fourth_edge) else $error("fourth rising edge missed");

endmodule

// ### logic/ccm_unit.sv
/*
 * Capture/compare mode unit with APB register file, a 16-bit timer three,
 * edge prescaler, compare latch, special event trigger and PWM pin steering.
 * Assumes the first timer count and pwm_modulation come from pclk logic;
 * the capture pin is asynchronous. Zero-wait APB slave.
 */
`timescale 1ns/1ns
module ccm_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              capture_compare_pin_in,
    input  wire logic [15:0]       first_timer_count,
    input  wire logic              adc_enabled,
    input  wire logic              pwm_modulation,
    output logic                   output_pin_a_out,
    output logic                   output_pin_a_oe,
    output logic                   output_pin_b_out,
    output logic                   output_pin_b_oe,
    output logic                   output_pin_c_out,
    output logic                   output_pin_c_oe,
    output logic                   output_pin_d_out,
    output logic                   output_pin_d_oe,
    output logic                   first_timer_reset,
    output logic                   adc_start,
    output logic [9:0]             duty_value,
    output logic                   capture_compare_flag,
    output logic                   timer_three_overflow_flag
);
    // Address decode needs the full offset range
    generate
        if (ADDR_W < 5) begin : g_bad_addr
            $error("ADDR_W too small for register map");
        end
    endgenerate

    logic [7:0]  value_low_ff;
    logic [7:0]  value_high_ff;
    logic [7:0]  mode_ctrl_ff;
    logic [7:0]  t3_ctrl_ff;
    logic [15:0] t3_count_ff;
    logic        cc_flag_ff;
    logic        t3_ovf_ff;
    logic        cmp_latch_ff;
    logic        match_prev_ff;
    logic        pin_meta_ff;
    logic        pin_sync_ff;
    logic        first_reset_ff;
    logic        adc_start_ff;
    logic [3:0]  pin_out_ff;
    logic [3:0]  pin_oe_ff;
    logic [3:0]  nxt_pin_out;
    logic [3:0]  nxt_pin_oe;

    logic [3:0]  unit_mode_code;
    logic [1:0]  output_steering_config;
    logic [1:0]  duty_fraction_bits;
    logic        time_base_select;
    logic        t3_on;
    logic [15:0] capture_compare_value;
    logic [15:0] sel_count;
    logic [7:0]  addr_b;
    logic        apb_wr;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_mode;
    logic        wr_t3lo;
    logic        wr_t3hi;
    logic        wr_t3ctrl;
    logic        wr_status;
    logic        mapped;
    logic        capture_event;
    logic        match_now;
    logic        match_pulse;
    logic        trigger;
    logic        trig_t3;
    logic        t3_wrap;
    ccm_pkg::ccm_class_t mode_class;

    // Classify the mode code; reserved codes fall into off
    function automatic ccm_pkg::ccm_class_t classify(input logic [3:0] code);
        if (code[3:2] == 2'b01) begin
            return ccm_pkg::CLS_CAPTURE;
        end else if (code[3:2] == 2'b11) begin
            return ccm_pkg::CLS_PWM;
        end else if (code[3:2] == 2'b10 || code == ccm_pkg::MODE_CMP_TOGGLE) begin
            return ccm_pkg::CLS_COMPARE;
        end
        return ccm_pkg::CLS_OFF;
    endfunction

    // Apply active-low polarity to a pin level
    function automatic logic polar(input logic level, input logic active_low);
        return level ^ active_low;
    endfunction

    // Field views of the mode, timer three control and value registers
    assign unit_mode_code         = mode_ctrl_ff[ccm_pkg::MODE_MSB:ccm_pkg::MODE_LSB];
    assign output_steering_config = mode_ctrl_ff[ccm_pkg::STEER_MSB:ccm_pkg::STEER_LSB];
    assign duty_fraction_bits     = mode_ctrl_ff[ccm_pkg::DUTY_MSB:ccm_pkg::DUTY_LSB];
    assign time_base_select       = t3_ctrl_ff[ccm_pkg::T3_TIMEBASE_BIT];
    assign t3_on                  = t3_ctrl_ff[ccm_pkg::T3_ON_BIT];
    assign capture_compare_value  = {value_high_ff, value_low_ff};
    assign mode_class             = classify(unit_mode_code);
    assign sel_count              = time_base_select ? t3_count_ff : first_timer_count;

    // APB decode, zero wait states
    assign addr_b    = 8'(paddr);
    assign apb_wr    = psel & penable & pwrite;
    assign wr_lo     = apb_wr && addr_b == ccm_pkg::OFS_VALUE_LOW;
    assign wr_hi     = apb_wr && addr_b == ccm_pkg::OFS_VALUE_HIGH;
    assign wr_mode   = apb_wr && addr_b == ccm_pkg::OFS_MODE_CONTROL;
    assign wr_t3lo   = apb_wr && addr_b == ccm_pkg::OFS_T3_COUNT_LOW;
    assign wr_t3hi   = apb_wr && addr_b == ccm_pkg::OFS_T3_COUNT_HI;
    assign wr_t3ctrl = apb_wr && addr_b == ccm_pkg::OFS_T3_CONTROL;
    assign wr_status = apb_wr && addr_b == ccm_pkg::OFS_STATUS;
    assign pready    = 1'b1;

    // Read mux; unmapped offsets read zero and answer with an error
    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0000_0000;
        case (addr_b)
            ccm_pkg::OFS_VALUE_LOW:    prdata[7:0] = value_low_ff;
            ccm_pkg::OFS_VALUE_HIGH:   prdata[7:0] = value_high_ff;
            ccm_pkg::OFS_MODE_CONTROL: prdata[7:0] = mode_ctrl_ff;
            ccm_pkg::OFS_T3_COUNT_LOW: prdata[7:0] = t3_count_ff[7:0];
            ccm_pkg::OFS_T3_COUNT_HI:  prdata[7:0] = t3_count_ff[15:8];
            ccm_pkg::OFS_T3_CONTROL:   prdata[7:0] = t3_ctrl_ff;
            ccm_pkg::OFS_STATUS: begin
                prdata[ccm_pkg::STS_CC_FLAG_BIT] = cc_flag_ff;
                prdata[ccm_pkg::STS_T3_OVF_BIT]  = t3_ovf_ff;
            end
            default:                   mapped = 1'b0;
        endcase
        pslverr = psel & penable & ~mapped;
    end

    // Capture pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= capture_compare_pin_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    ccm_edge_prescaler u_prescaler (
        .pclk          (pclk),
        .presetn       (presetn),
        .pin_level     (pin_sync_ff),
        .mode_code     (unit_mode_code),
        .capture_event (capture_event)
    );

    // Mode and timer control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl_ff <= ccm_pkg::RST_MODE_CONTROL;
            t3_ctrl_ff   <= ccm_pkg::RST_T3_CONTROL;
        end else begin
            if (wr_mode) begin
                mode_ctrl_ff <= pwdata[7:0];
            end
            if (wr_t3ctrl) begin
                t3_ctrl_ff <= pwdata[7:0] & ccm_pkg::T3_CONTROL_MASK;
            end
        end
    end

    // Value pair: a capture overwrites, and beats a same-cycle software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_low_ff  <= ccm_pkg::RST_VALUE_BYTE;
            value_high_ff <= ccm_pkg::RST_VALUE_BYTE;
        end else if (capture_event && mode_class == ccm_pkg::CLS_CAPTURE) begin
            value_low_ff  <= sel_count[7:0];
            value_high_ff <= sel_count[15:8];
        end else begin
            if (wr_lo) begin
                value_low_ff <= pwdata[7:0];
            end
            if (wr_hi) begin
                value_high_ff <= pwdata[7:0];
            end
        end
    end

    // Match is taken on the first equal cycle so a stalled timer flags once
    assign match_now   = (mode_class == ccm_pkg::CLS_COMPARE) && (sel_count == capture_compare_value);
    assign match_pulse = match_now & ~match_prev_ff;
    assign trigger     = match_pulse && unit_mode_code == ccm_pkg::MODE_CMP_TRIGGER;
    assign trig_t3     = trigger & time_base_select;
    assign t3_wrap     = t3_on && t3_count_ff == 16'hFFFF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_prev_ff <= 1'b0;
        end else begin
            match_prev_ff <= match_now;
        end
    end

    // Timer three: write wins over trigger reset; only internal 1:1 clocking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t3_count_ff <= ccm_pkg::RST_T3_COUNT;
        end else if (wr_t3lo) begin
            t3_count_ff <= {t3_count_ff[15:8], pwdata[7:0]};
        end else if (wr_t3hi) begin
            t3_count_ff <= {pwdata[7:0], t3_count_ff[7:0]};
        end else if (trig_t3) begin
            t3_count_ff <= 16'h0000;
        end else if (t3_on) begin
            t3_count_ff <= t3_count_ff + 16'h0001;
        end
    end

    // Sticky flags; hardware set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_flag_ff <= 1'b0;
            t3_ovf_ff  <= 1'b0;
        end else begin
            if (match_pulse || (capture_event && mode_class == ccm_pkg::CLS_CAPTURE)) begin
                cc_flag_ff <= 1'b1;
            end else if (wr_status && pwdata[ccm_pkg::STS_CC_FLAG_BIT]) begin
                cc_flag_ff <= 1'b0;
            end
            if (t3_wrap && !wr_t3lo && !wr_t3hi && !trig_t3) begin
                t3_ovf_ff <= 1'b1;
            end else if (wr_status && pwdata[ccm_pkg::STS_T3_OVF_BIT]) begin
                t3_ovf_ff <= 1'b0;
            end
        end
    end

    // Compare output latch; mode off forces it low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_latch_ff <= 1'b0;
        end else if (unit_mode_code == ccm_pkg::MODE_OFF) begin
            cmp_latch_ff <= 1'b0;
        end else if (match_pulse) begin
            case (unit_mode_code)
                ccm_pkg::MODE_CMP_TOGGLE: cmp_latch_ff <= ~cmp_latch_ff;
                ccm_pkg::MODE_CMP_SET:    cmp_latch_ff <= 1'b1;
                ccm_pkg::MODE_CMP_CLEAR:  cmp_latch_ff <= 1'b0;
                default:                  cmp_latch_ff <= cmp_latch_ff;
            endcase
        end
    end

    // Trigger side effects, registered pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reset_ff <= 1'b0;
            adc_start_ff   <= 1'b0;
        end else begin
            first_reset_ff <= trigger & ~time_base_select;
            adc_start_ff   <= trigger & adc_enabled;
        end
    end

    // Pin steering and polarity; bit 0 of the code inverts b and d, bit 1 a and c
    always_comb begin
        nxt_pin_out = 4'h0;
        nxt_pin_oe  = 4'h0;
        if (mode_class == ccm_pkg::CLS_PWM) begin
            case (output_steering_config)
                ccm_pkg::STEER_SINGLE: begin
                    nxt_pin_out[0] = pwm_modulation;
                    nxt_pin_oe     = 4'b0001;
                end
                ccm_pkg::STEER_FULL_FWD: begin
                    nxt_pin_out = {pwm_modulation, 1'b0, 1'b0, 1'b1};
                    nxt_pin_oe  = 4'b1111;
                end
                ccm_pkg::STEER_HALF: begin
                    nxt_pin_out = {1'b0, 1'b0, ~pwm_modulation, pwm_modulation};
                    nxt_pin_oe  = 4'b0011;
                end
                ccm_pkg::STEER_FULL_REV: begin
                    nxt_pin_out = {1'b0, 1'b1, pwm_modulation, 1'b0};
                    nxt_pin_oe  = 4'b1111;
                end
                default: begin
                    nxt_pin_oe = 4'h0;
                end
            endcase
            nxt_pin_out[0] = polar(nxt_pin_out[0], unit_mode_code[1]);
            nxt_pin_out[2] = polar(nxt_pin_out[2], unit_mode_code[1]);
            nxt_pin_out[1] = polar(nxt_pin_out[1], unit_mode_code[0]);
            nxt_pin_out[3] = polar(nxt_pin_out[3], unit_mode_code[0]);
        end else if (mode_class == ccm_pkg::CLS_COMPARE && unit_mode_code != ccm_pkg::MODE_CMP_SOFT
                     && unit_mode_code != ccm_pkg::MODE_CMP_TRIGGER) begin
            nxt_pin_out[0] = cmp_latch_ff;
            nxt_pin_oe[0]  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 4'h0;
            pin_oe_ff  <= 4'h0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
        end
    end

    // Output wiring
    assign {output_pin_d_out, output_pin_c_out, output_pin_b_out, output_pin_a_out} = pin_out_ff;
    assign {output_pin_d_oe, output_pin_c_oe, output_pin_b_oe, output_pin_a_oe}     = pin_oe_ff;
    assign duty_value                = {value_low_ff, duty_fraction_bits};
    assign first_timer_reset         = first_reset_ff;
    assign adc_start                 = adc_start_ff;
    assign capture_compare_flag      = cc_flag_ff;
    assign timer_three_overflow_flag = t3_ovf_ff;

    property p_trig_reset;
        @(posedge pclk) disable iff (!presetn)
        (trig_t3 && !wr_t3lo && !wr_t3hi) |=> t3_count_ff == 16'h0000;
    endproperty
    a_trig_reset: assert property (p_trig_reset) else $error("trigger did not reset timer three");

    property p_trig_no_ovf;
        @(posedge pclk) disable iff (!presetn)
        (trig_t3 && !t3_ovf_ff) |=> !t3_ovf_ff;
    endproperty
    a_trig_no_ovf: assert property (p_trig_no_ovf) else $error("trigger set overflow flag");

    property p_write_wins;
        @(posedge pclk) disable iff (!presetn)
        (trig_t3 && wr_t3lo) |=> t3_count_ff[7:0] == $past(pwdata[7:0]) && t3_count_ff[15:8] == $past(t3_count_ff[15:8]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("trigger beat timer write");

    property p_capture_copy;
        @(posedge pclk) disable iff (!presetn)
        (capture_event && mode_class == ccm_pkg::CLS_CAPTURE) |=> capture_compare_value == $past(sel_count);
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture value wrong");

    property p_capture_flag;
        @(posedge pclk) disable iff (!presetn)
        (capture_event && mode_class == ccm_pkg::CLS_CAPTURE) |=> cc_flag_ff;
    endproperty
    a_capture_flag: assert property (p_capture_flag) else $error("capture flag not set");

    property p_set_on_match;
        @(posedge pclk) disable iff (!presetn)
        (match_pulse && unit_mode_code == ccm_pkg::MODE_CMP_SET && !wr_mode) |=> cmp_latch_ff ##1 output_pin_a_out;
    endproperty
    a_set_on_match: assert property (p_set_on_match) else $error("set on match failed");

    property p_off_clears;
        @(posedge pclk) disable iff (!presetn)
        (unit_mode_code == ccm_pkg::MODE_OFF && !wr_mode) |=> !cmp_latch_ff ##1 !output_pin_a_oe;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("off mode left latch or pin");

endmodule

// ### pkg/ccm_pkg.sv
/*
 * Constants for the capture/compare mode unit: register byte offsets,
 * field positions, reset values, mode codes and prescale counts.
 * Assumes a 32-bit APB slave port with word-aligned registers.
 */
package ccm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_VALUE_LOW    = 8'h00;
    localparam logic [7:0] OFS_VALUE_HIGH   = 8'h04;
    localparam logic [7:0] OFS_MODE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_T3_COUNT_LOW = 8'h0C;
    localparam logic [7:0] OFS_T3_COUNT_HI  = 8'h10;
    localparam logic [7:0] OFS_T3_CONTROL   = 8'h14;
    localparam logic [7:0] OFS_STATUS       = 8'h18;

    // Reset values
    localparam logic [7:0]  RST_MODE_CONTROL = 8'h00;
    localparam logic [7:0]  RST_T3_CONTROL   = 8'h00;
    localparam logic [7:0]  RST_VALUE_BYTE   = 8'h00;
    localparam logic [15:0] RST_T3_COUNT     = 16'h0000;

    // Mode control fields
    localparam int STEER_MSB = 7;
    localparam int STEER_LSB = 6;
    localparam int DUTY_MSB  = 5;
    localparam int DUTY_LSB  = 4;
    localparam int MODE_MSB  = 3;
    localparam int MODE_LSB  = 0;

    // Timer three control fields; bit 6 is unimplemented
    localparam int          T3_ON_BIT       = 0;
    localparam int          T3_TIMEBASE_BIT = 3;
    localparam logic [7:0]  T3_CONTROL_MASK = 8'hBF;

    // Status fields, write one to clear
    localparam int STS_CC_FLAG_BIT  = 0;
    localparam int STS_T3_OVF_BIT   = 1;

    // Unit mode codes
    localparam logic [3:0] MODE_OFF          = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL     = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE     = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4    = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16   = 4'h7;
    localparam logic [3:0] MODE_CMP_SET      = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR    = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT     = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIGGER  = 4'hB;

    // Output steering codes in PWM mode
    localparam logic [1:0] STEER_SINGLE      = 2'h0;
    localparam logic [1:0] STEER_FULL_FWD    = 2'h1;
    localparam logic [1:0] STEER_HALF        = 2'h2;
    localparam logic [1:0] STEER_FULL_REV    = 2'h3;

    // Capture prescale edge counts
    localparam logic [3:0] PRESCALE_LAST4    = 4'h3;
    localparam logic [3:0] PRESCALE_LAST16   = 4'hF;

    typedef enum logic [1:0] {
        CLS_OFF,
        CLS_CAPTURE,
        CLS_COMPARE,
        CLS_PWM
    } ccm_class_t;

endpackage

// ### tb/ccm_partner.sv
/* Partner model: first timer count and capture pin.
   Assumes bench requests change just after pclk edges. */
`timescale 1ns/1ns
module ccm_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] load_val,
    input  wire logic        load_en,
    input  wire logic        pin_req,
    input  wire logic        timer_clear,
    output logic [15:0]      first_timer_count,
    output logic             pin_level
);
    // Timer held still in pclk domain so a capture is exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) first_timer_count <= 16'h0000;
        else if (timer_clear) first_timer_count <= 16'h0000;
        else if (load_en) first_timer_count <= load_val;
    end
    // Pin level, each held four cycles by the bench
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pin_level <= 1'b0;
        else pin_level <= pin_req;
    end
endmodule

// ### tb/tb_capture_compare_mode_unit.sv
/* Bench: registers, capture, prescale, compare, trigger.
   Assumes the zero-wait APB slave and the partner model. */
`timescale 1ns/1ns
module tb_capture_compare_mode_unit;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [15:0] load_val = 16'h0000, ftc;
    logic        pin_req = 0, load_en = 0, adc_en = 0, er, pin, pready, pslverr;
    logic        pa, pa_oe, flag, ftr, adcs, seen_r, seen_a;
    logic        pwm_mod = 0, pb, pc, pd, pb_oe, pc_oe, pd_oe, ovf;
    logic [9:0]  duty;
    int          mismatches = 0, checked = 0;
    // Clock of 50 ns
    always #25 pclk = ~pclk;
    ccm_partner far (.pclk(pclk), .presetn(presetn), .load_val(load_val), .load_en(load_en),
        .pin_req(pin_req), .timer_clear(ftr), .first_timer_count(ftc), .pin_level(pin));
    ccm_unit dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .capture_compare_pin_in(pin), .first_timer_count(ftc), .adc_enabled(adc_en),
        .pwm_modulation(pwm_mod), .output_pin_a_out(pa), .output_pin_a_oe(pa_oe), .output_pin_b_out(pb),
        .output_pin_b_oe(pb_oe), .output_pin_c_out(pc), .output_pin_c_oe(pc_oe), .output_pin_d_out(pd),
        .output_pin_d_oe(pd_oe), .first_timer_reset(ftr), .adc_start(adcs), .duty_value(duty),
        .capture_compare_flag(flag), .timer_three_overflow_flag(ovf));
    task tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer; a hung slave ends the run
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t apb transfer timed out", $time);
            tally_and_finish();
        end
        // Idle edge so the next call never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task pulse();
        pin_req <= 1;
        cyc(4);
        pin_req <= 0;
        cyc(4);
    endtask
    task load(input logic [15:0] v);
        load_val <= v;
        load_en <= 1;
        cyc(1);
        load_en <= 0;
    endtask
    task t_regs();
        apb(0, 8'h08, 8'h00);
        chk(rd, 32'h0);
        apb(1, 8'h00, 8'h5A);
        apb(0, 8'h00, 8'h00);
        chk(rd, 32'h5A);
        apb(0, 8'h1C, 8'h00);
        chk({31'h0, er}, 32'h1);
    endtask
    // Capture, then fourth-edge prescale after a clean mode change
    task t_capture();
        load(16'h1234);
        apb(1, 8'h08, 8'h05);
        pulse();
        apb(0, 8'h04, 8'h00);
        chk(rd, 32'h12);
        chk({31'h0, flag}, 32'h1);
        apb(1, 8'h18, 8'h01);
        apb(1, 8'h08, 8'h00);
        apb(1, 8'h08, 8'h06);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                apb(0, 8'h00, 8'h00);
                chk({rd[7:0], 7'h0, flag}, 32'h3400);
                load(16'h00BB);
            end
            pulse();
        end
        apb(0, 8'h00, 8'h00);
        chk(rd, 32'hBB);
    endtask
    task t_compare();
        apb(1, 8'h08, 8'h00);
        load(16'h0000);
        apb(1, 8'h00, 8'h10);
        apb(1, 8'h04, 8'h00);
        apb(1, 8'h08, 8'h08);
        load(16'h0010);
        cyc(4);
        chk({30'h0, pa_oe, pa}, 32'h3);
        load(16'h0000);
        apb(1, 8'h08, 8'h09);
        load(16'h0010);
        cyc(4);
        chk({30'h0, pa_oe, pa}, 32'h2);
    endtask
    task t_trigger();
        adc_en <= 1;
        load(16'h0000);
        apb(1, 8'h08, 8'h0B);
        seen_r = 0;
        seen_a = 0;
        load(16'h0010);
        repeat (6) begin @(posedge pclk); seen_r |= ftr; seen_a |= adcs; end
        chk({30'h0, seen_r, seen_a}, 32'h3);
        chk({16'h0, ftc}, 32'h0);
        chk({31'h0, pa_oe}, 32'h0);
        apb(1, 8'h18, 8'h01);
        apb(1, 8'h08, 8'h0A);
        load(16'h0010);
        cyc(3);
        chk({30'h0, pa_oe, flag}, 32'h1);
    endtask
    // Forward bridge, then half bridge with both pairs active low
    task t_pwm();
        pwm_mod <= 1;
        apb(1, 8'h08, 8'h4C);
        cyc(2);
        chk({pd_oe, pc_oe, pb_oe, pa_oe, pd, pc, pb, pa}, 32'hF9);
        apb(1, 8'h08, 8'hBF);
        cyc(2);
        chk({pd_oe, pc_oe, pb_oe, pa_oe, pd, pc, pb, pa}, 32'h3E);
        chk({22'h0, duty}, 32'h43);
    endtask
    // Timer three with trigger period 8; reads stride 3 so all phases are seen
    task t_timer3();
        int mx;
        mx = 0;
        apb(1, 8'h08, 8'h00);
        apb(1, 8'h00, 8'h07);
        apb(1, 8'h04, 8'h00);
        apb(1, 8'h08, 8'h0B);
        apb(1, 8'h14, 8'h09);
        repeat (16) begin
            apb(0, 8'h0C, 8'h00);
            if (rd > mx) mx = rd;
        end
        chk(mx, 32'h7);
        chk({31'h0, ovf}, 32'h0);
    endtask
    // Reset for four cycles, then the scenarios
    initial begin
        cyc(4);
        presetn <= 1;
        cyc(1);
        t_regs();
        t_capture();
        t_compare();
        t_trigger();
        t_pwm();
        t_timer3();
        tally_and_finish();
    end
endmodule
